// ===== sss_far_side.sv
// Far side model: power stages and host select writes.
// Assumes one clock shared with the supervisor.
`timescale 1ns/1ps
`default_nettype none
module sss_far_side (
   input wire logic clk,
   input wire logic rst,
   input wire logic [6:0] channel_enable,
   input wire logic [6:0] short_ch,
   input wire logic [1:0] sel_req,
   input wire logic [1:0] ext_ok,
   output logic [6:0] ch_out_low,
   output logic [2:0] low_side_end,
   output logic rail_a_source_select,
   output logic rail_b_source_select
);
   logic [1:0] ph_q;
   // ----
   // Power stages
   // ----
   // Output low while off or shorted; low-side end every fourth cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q <= 2'h0;
         ch_out_low <= 7'h7F;
      end else begin
         ph_q <= ph_q + 2'h1;
         ch_out_low <= ~channel_enable | short_ch;
      end
   end
   assign low_side_end = {3{ph_q == 2'h3}};
   // Host sets select only once the source has settled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {rail_b_source_select, rail_a_source_select} <= 2'h0;
      end else begin
         {rail_b_source_select, rail_a_source_select} <= sel_req & ext_ok;
      end
   end
endmodule
`default_nettype wire

// ===== sss_pkg.sv
// Package for the supply supervisor and source select block.
// Assumes a single 40 MHz clock domain and no register bus.
package sss_pkg;

   // ----------------------------------------
   // Channel counts and widths
   // ----------------------------------------
   localparam int unsigned CH_NUM = 7;
   localparam int unsigned VALLEY_CH_NUM = 3;
   localparam int unsigned VCODE_W = 6;

   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [6:0] DSCG_RST = 7'h00;
   localparam logic [5:0] VCODE_RST = 6'h00;
   // Channel 3 code that selects adjustable (external divider) mode
   localparam logic [5:0] CH3_ADJ_CODE = 6'h3F;

   // ----------------------------------------
   // Timing: keep-alive A to B start spacing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned KA_GAP_NS = 1000;
   localparam int unsigned KA_GAP_CYC = (KA_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned KA_CNT_W = 8;

   // ----------------------------------------
   // Supervisor states
   // ----------------------------------------
   typedef enum logic [4:0] {
      SSS_OFF     = 5'b00001,
      SSS_KA_A    = 5'b00010,
      SSS_STANDBY = 5'b00100,
      SSS_RUN     = 5'b01000,
      SSS_LATCHED = 5'b10000
   } sss_state_t;

endpackage

// ===== sss_supervisor.sv
// Supervisory logic: undervoltage shutdown, keep-alive start order,
// discharge switches, takeover source select and valley pulse skipping.
// Assumes comparator and pin inputs are asynchronous; all pass two flops.

`timescale 1ns/1ps
`default_nettype none

module sss_supervisor #(
   parameter int unsigned CH_NUM = sss_pkg::CH_NUM,
   parameter int unsigned VCODE_W = sss_pkg::VCODE_W
) (
   input wire logic clk,
   input wire logic rst,
   // Comparator and pin inputs, asynchronous
   input wire logic enable_pin,
   input wire logic battery_uv,
   input wire logic ch1_input_uv,
   input wire logic gate_drive_uv,
   input wire logic logic_rail_por,
   input wire logic rail_a_ext_low,
   input wire logic rail_b_ext_low,
   input wire logic rail_a_ext_oc,
   input wire logic rail_b_ext_oc,
   input wire logic [2:0] valley_over_limit,
   input wire logic [2:0] low_side_end,
   input wire logic [CH_NUM-1:0] ch_out_low,
   // Software control bits, same clock domain
   input wire logic rail_a_source_select,
   input wire logic rail_b_source_select,
   input wire logic [CH_NUM-1:0] channel_on_cmd,
   input wire logic [CH_NUM-1:0] dscg_wr_data,
   input wire logic dscg_wr,
   input wire logic [3*VCODE_W-1:0] vcode_wr_data,
   input wire logic vcode_wr,
   // Fuse defaults, static
   input wire logic [CH_NUM-1:0] fuse_discharge_enable,
   input wire logic [3*VCODE_W-1:0] fuse_voltage_code,
   // Outputs
   output logic [CH_NUM-1:0] channel_enable,
   output logic charge_pump_enable,
   output logic keepalive_regulator_a_en,
   output logic keepalive_regulator_b_en,
   output logic [CH_NUM-1:0] channel_discharge_on,
   output logic rail_a_discharge_on,
   output logic rail_b_discharge_on,
   output logic rail_a_ext_connect,
   output logic rail_b_ext_connect,
   output logic [2:0] pulse_skip,
   output logic [CH_NUM-1:0] channel_power_good_flag,
   output logic [CH_NUM-1:0] channel_undervoltage_flag,
   output logic fault_flag,
   output logic [CH_NUM-1:0] channel_discharge_enable,
   output logic [3*VCODE_W-1:0] channel_voltage_code,
   output logic ch3_adjustable_mode,
   output logic supervisor_standby,
   output logic uv_shutdown_latched
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int unsigned SYNC_W = 9 + 3 + 3 + CH_NUM;

   logic [SYNC_W-1:0] sync_raw;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;

   assign sync_raw = {enable_pin, battery_uv, ch1_input_uv, gate_drive_uv, logic_rail_por,
                      rail_a_ext_low, rail_b_ext_low, rail_a_ext_oc, rail_b_ext_oc,
                      valley_over_limit, low_side_end, ch_out_low};

   // Two flops per asynchronous input
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= sync_raw;
         sync2_q <= sync1_q;
      end
   end

   logic en_s;
   logic batt_uv_s;
   logic ch1_uv_s;
   logic gd_uv_s;
   logic por_s;
   logic a_low_s;
   logic b_low_s;
   logic a_oc_s;
   logic b_oc_s;
   logic [2:0] valley_s;
   logic [2:0] lse_s;
   logic [CH_NUM-1:0] out_low_s;

   assign {en_s, batt_uv_s, ch1_uv_s, gd_uv_s, por_s, a_low_s, b_low_s, a_oc_s, b_oc_s,
           valley_s, lse_s, out_low_s} = sync2_q;

   // ----------------------------------------
   // Internal reset and enable toggle
   // ----------------------------------------
   // Battery low or logic rail low resets the register state
   logic soft_rst;
   assign soft_rst = batt_uv_s | por_s;

   logic en_prev_q;
   logic en_seen_low_q;
   logic en_toggle;

   // Toggle is a low level followed by a rising edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_prev_q <= 1'b0;
         en_seen_low_q <= 1'b0;
      end else begin
         en_prev_q <= en_s;
         if (!en_s) begin
            en_seen_low_q <= 1'b1;
         end else if (en_toggle) begin
            en_seen_low_q <= 1'b0;
         end
      end
   end

   assign en_toggle = en_s & ~en_prev_q & en_seen_low_q;

   // ----------------------------------------
   // Supervisor state machine
   // ----------------------------------------
   // Last count of the keep-alive A to B gap
   localparam int unsigned KA_LAST = sss_pkg::KA_GAP_CYC - 1;

   logic [sss_pkg::KA_CNT_W-1:0] ka_cnt_q;
   sss_pkg::sss_state_t state_q;
   logic uv_event;

   assign uv_event = ch1_uv_s | gd_uv_s;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= sss_pkg::SSS_OFF;
         ka_cnt_q <= '0;
      end else if (soft_rst) begin
         state_q <= sss_pkg::SSS_OFF;
         ka_cnt_q <= '0;
      end else begin
         unique case (state_q)
            sss_pkg::SSS_OFF: begin
               state_q <= sss_pkg::SSS_KA_A;
               ka_cnt_q <= '0;
            end
            sss_pkg::SSS_KA_A: begin
               if (ka_cnt_q == KA_LAST[sss_pkg::KA_CNT_W-1:0]) begin
                  state_q <= sss_pkg::SSS_STANDBY;
               end else begin
                  ka_cnt_q <= ka_cnt_q + 1'b1;
               end
            end
            sss_pkg::SSS_STANDBY: begin
               if (!uv_event && en_s) begin
                  state_q <= sss_pkg::SSS_RUN;
               end
            end
            sss_pkg::SSS_RUN: begin
               if (uv_event) begin
                  state_q <= sss_pkg::SSS_LATCHED;
               end else if (!en_s) begin
                  state_q <= sss_pkg::SSS_STANDBY;
               end
            end
            sss_pkg::SSS_LATCHED: begin
               if (en_toggle && !uv_event) begin
                  state_q <= sss_pkg::SSS_RUN;
               end
            end
            default: begin
               state_q <= sss_pkg::SSS_OFF;
            end
         endcase
      end
   end

   logic running;
   assign running = (state_q == sss_pkg::SSS_RUN) & ~uv_event;

   // Channel and keep-alive enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         channel_enable <= '0;
         charge_pump_enable <= 1'b0;
         keepalive_regulator_a_en <= 1'b0;
         keepalive_regulator_b_en <= 1'b0;
      end else begin
         channel_enable <= running ? channel_on_cmd : '0;
         charge_pump_enable <= running;
         keepalive_regulator_a_en <= ~soft_rst & (state_q != sss_pkg::SSS_OFF);
         keepalive_regulator_b_en <= ~soft_rst & (state_q != sss_pkg::SSS_OFF)
                                     & (state_q != sss_pkg::SSS_KA_A);
      end
   end

   assign supervisor_standby = (state_q == sss_pkg::SSS_STANDBY);
   assign uv_shutdown_latched = (state_q == sss_pkg::SSS_LATCHED);

   // ----------------------------------------
   // Fuse-loaded settings
   // ----------------------------------------
   logic fuse_load_q;

   // Load fuse defaults after any reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fuse_load_q <= 1'b1;
         channel_discharge_enable <= sss_pkg::DSCG_RST;
         channel_voltage_code <= {3{sss_pkg::VCODE_RST}};
      end else if (soft_rst || fuse_load_q) begin
         fuse_load_q <= soft_rst;
         channel_discharge_enable <= fuse_discharge_enable;
         channel_voltage_code <= fuse_voltage_code;
      end else begin
         if (dscg_wr) begin
            channel_discharge_enable <= dscg_wr_data;
         end
         if (vcode_wr) begin
            channel_voltage_code <= vcode_wr_data;
         end
      end
   end

   assign ch3_adjustable_mode =
      (channel_voltage_code[3*VCODE_W-1 -: VCODE_W] == sss_pkg::CH3_ADJ_CODE);

   // ----------------------------------------
   // Discharge switches
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         channel_discharge_on <= '0;
         rail_a_discharge_on <= 1'b0;
         rail_b_discharge_on <= 1'b0;
      end else begin
         channel_discharge_on <= channel_discharge_enable
                                 & ({CH_NUM{~en_s}} | ~channel_on_cmd);
         rail_a_discharge_on <= batt_uv_s;
         rail_b_discharge_on <= batt_uv_s;
      end
   end

   // ----------------------------------------
   // Takeover inputs
   // ----------------------------------------
   logic a_oc_lat_q;
   logic b_oc_lat_q;

   // Overcurrent latches, set wins over toggle clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         a_oc_lat_q <= 1'b0;
         b_oc_lat_q <= 1'b0;
      end else if (soft_rst) begin
         a_oc_lat_q <= 1'b0;
         b_oc_lat_q <= 1'b0;
      end else begin
         a_oc_lat_q <= a_oc_s | (a_oc_lat_q & ~en_toggle);
         b_oc_lat_q <= b_oc_s | (b_oc_lat_q & ~en_toggle);
      end
   end

   // Connect only when enabled, selected, healthy and not latched off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rail_a_ext_connect <= 1'b0;
         rail_b_ext_connect <= 1'b0;
      end else begin
         rail_a_ext_connect <= en_s & rail_a_source_select & ~a_low_s & ~a_oc_s
                               & ~a_oc_lat_q & ~soft_rst;
         rail_b_ext_connect <= en_s & rail_b_source_select & ~b_low_s & ~b_oc_s
                               & ~b_oc_lat_q & ~soft_rst;
      end
   end

   // ----------------------------------------
   // Valley current limit, channels 1 to 3
   // ----------------------------------------
   logic [2:0] skip_q;

   generate
      for (genvar i = 0; i < sss_pkg::VALLEY_CH_NUM; i++) begin : g_valley
         // Sample at end of low-side phase; hold until current drops
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               skip_q[i] <= 1'b0;
            end else if (lse_s[i]) begin
               skip_q[i] <= valley_s[i] & channel_enable[i];
            end
         end
      end
   endgenerate

   assign pulse_skip = skip_q;

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         channel_power_good_flag <= '0;
         channel_undervoltage_flag <= '0;
         fault_flag <= 1'b0;
      end else begin
         channel_power_good_flag <= channel_enable & ~out_low_s;
         channel_undervoltage_flag <= channel_enable & out_low_s;
         fault_flag <= |(channel_enable & out_low_s) | uv_event;
      end
   end

endmodule

`default_nettype wire

// ===== sss_supervisor_asserts.sv
// Port assertions for the supply supervisor.
// Assumes binding into every sss_supervisor instance.
`timescale 1ns/1ps
`default_nettype none
module sss_chk #(
   parameter int unsigned CH_NUM = sss_pkg::CH_NUM,
   parameter int unsigned VCODE_W = sss_pkg::VCODE_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable_pin,
   input wire logic battery_uv,
   input wire logic ch1_input_uv,
   input wire logic gate_drive_uv,
   input wire logic rail_a_ext_low,
   input wire logic rail_b_ext_low,
   input wire logic rail_a_ext_oc,
   input wire logic rail_b_ext_oc,
   input wire logic [CH_NUM-1:0] channel_enable,
   input wire logic charge_pump_enable,
   input wire logic keepalive_regulator_a_en,
   input wire logic keepalive_regulator_b_en,
   input wire logic rail_a_discharge_on,
   input wire logic rail_b_discharge_on,
   input wire logic rail_a_ext_connect,
   input wire logic rail_b_ext_connect,
   input wire logic [3*VCODE_W-1:0] channel_voltage_code,
   input wire logic ch3_adjustable_mode
);
   // ----
   // Shutdown, start order, takeover
   // ----
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_CH1_UV: assert property (
      ch1_input_uv [*5] |-> channel_enable == '0 && !charge_pump_enable)
      else $error("channels on during input uv");
   AST_GD_UV: assert property (
      gate_drive_uv [*5] |-> channel_enable == '0)
      else $error("channels on during gate drive uv");
   AST_BATT_UV: assert property (
      battery_uv [*5] |-> !keepalive_regulator_a_en && !keepalive_regulator_b_en)
      else $error("keep-alive on during battery uv");
   AST_KA_ORDER: assert property (
      keepalive_regulator_b_en |-> $past(keepalive_regulator_a_en, 8))
      else $error("keep-alive b before a");
   AST_EXT_EN: assert property (
      !enable_pin [*5] |-> !rail_a_ext_connect && !rail_b_ext_connect)
      else $error("takeover active with enable low");
   AST_A_LOW: assert property (
      rail_a_ext_low [*5] |-> !rail_a_ext_connect)
      else $error("rail a kept on low input");
   AST_B_LOW: assert property (
      rail_b_ext_low [*5] |-> !rail_b_ext_connect)
      else $error("rail b kept on low input");
   AST_A_OC: assert property (
      rail_a_ext_oc [*4] |=> !rail_a_ext_connect [*6])
      else $error("rail a reconnected after overcurrent");
   AST_B_OC: assert property (
      rail_b_ext_oc [*4] |=> !rail_b_ext_connect [*6])
      else $error("rail b reconnected after overcurrent");
   AST_KA_DSCG: assert property (
      battery_uv [*5] |-> rail_a_discharge_on && rail_b_discharge_on)
      else $error("rail discharge off on battery low");
   AST_ADJ: assert property (
      ch3_adjustable_mode
         == (channel_voltage_code[3*VCODE_W-1 -: VCODE_W] == sss_pkg::CH3_ADJ_CODE))
      else $error("adjustable mode decode wrong");
endmodule
bind sss_supervisor sss_chk #(.CH_NUM(CH_NUM), .VCODE_W(VCODE_W)) u_chk (
   .clk, .rst, .enable_pin, .battery_uv, .ch1_input_uv, .gate_drive_uv,
   .rail_a_ext_low, .rail_b_ext_low, .rail_a_ext_oc, .rail_b_ext_oc, .channel_enable,
   .charge_pump_enable, .keepalive_regulator_a_en, .keepalive_regulator_b_en,
   .rail_a_discharge_on, .rail_b_discharge_on, .rail_a_ext_connect,
   .rail_b_ext_connect, .channel_voltage_code, .ch3_adjustable_mode
);
`default_nettype wire

// ===== supply_supervisor_source_select_tb_top.sv
// Self-checking bench for the supply supervisor.
// Assumes the far side model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_source_select_tb_top;
   typedef struct packed {logic [4:0] stim; logic [6:0] ch; logic [4:0] ka;} sss_row_t;
   localparam logic [6:0] FUSE_DSC = 7'h55;
   localparam logic [17:0] FUSE_VC = 18'h3_F0A5;
   logic clk, rst, enable_pin, battery_uv, ch1_input_uv, gate_drive_uv, logic_rail_por;
   logic dscg_wr, vcode_wr, charge_pump_enable, keepalive_regulator_a_en;
   logic keepalive_regulator_b_en, rail_a_discharge_on, rail_b_discharge_on, fault_flag;
   logic rail_a_ext_connect, rail_b_ext_connect, ch3_adjustable_mode, supervisor_standby;
   logic uv_shutdown_latched, rail_a_source_select, rail_b_source_select;
   logic [1:0] ext_low, ext_oc, sel_req, ext_ok;
   logic [2:0] valley_over_limit, low_side_end, pulse_skip;
   logic [6:0] ch_out_low, channel_on_cmd, dscg_wr_data, short_ch, channel_enable;
   logic [6:0] channel_discharge_on, channel_power_good_flag, channel_undervoltage_flag;
   logic [6:0] channel_discharge_enable;
   logic [6:0] fuse_discharge_enable = FUSE_DSC;
   logic [17:0] fuse_voltage_code = FUSE_VC;
   logic [17:0] vcode_wr_data, channel_voltage_code;
   wire logic rail_a_ext_low = ext_low[0];
   wire logic rail_b_ext_low = ext_low[1];
   wire logic rail_a_ext_oc = ext_oc[0];
   wire logic rail_b_ext_oc = ext_oc[1];
   int compares = 0;
   int miscompares = 0;
   sss_row_t rows [10] = '{'{5'h01, 7'h7F, 5'h18}, '{5'h09, 7'h00, 5'h19},
      '{5'h01, 7'h00, 5'h19}, '{5'h00, 7'h00, 5'h19}, '{5'h01, 7'h7F, 5'h18},
      '{5'h05, 7'h00, 5'h19}, '{5'h00, 7'h00, 5'h19}, '{5'h01, 7'h7F, 5'h18},
      '{5'h11, 7'h00, 5'h06}, '{5'h01, 7'h00, 5'h10}};
   // ----
   // Design, far side, clock
   // ----
   sss_supervisor dut (.*);
   sss_far_side u_far (.clk(clk), .rst(rst), .channel_enable(channel_enable),
      .short_ch(short_ch), .sel_req(sel_req), .ext_ok(ext_ok), .ch_out_low(ch_out_low),
      .low_side_end(low_side_end), .rail_a_source_select(rail_a_source_select),
      .rail_b_source_select(rail_b_source_select));
   always #12.5 clk = ~clk;
   // ----
   // Helpers
   // ----
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Enable low then high again
   task automatic tog();
      enable_pin = 1'b0;
      wt(4);
      enable_pin = 1'b1;
      wt(8);
   endtask
   task automatic end_of_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog on a hang
   initial begin
      #(25 * 5000);
      miscompares++;
      end_of_test();
   end
   // ----
   // Main sequence
   // ----
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {enable_pin, battery_uv, ch1_input_uv, gate_drive_uv, logic_rail_por} = '0;
      {ext_low, ext_oc, sel_req, ext_ok, valley_over_limit, short_ch} = '0;
      {dscg_wr, vcode_wr, dscg_wr_data, vcode_wr_data} = '0;
      channel_on_cmd = 7'h7F;
      wt(4);
      chk(channel_enable, 7'h00, "reset channels");
      rst = 1'b0;
      wt(2);
      chk(channel_discharge_enable, FUSE_DSC, "fuse discharge");
      chk(ch3_adjustable_mode, 1'b1, "adjustable");
      wt(50);
      chk(supervisor_standby, 1'b1, "standby");
      foreach (rows[i]) begin
         {battery_uv, ch1_input_uv, gate_drive_uv, logic_rail_por, enable_pin} = rows[i].stim;
         wt(8);
         chk(channel_enable, rows[i].ch, "channels");
         chk(charge_pump_enable, |rows[i].ch, "pump");
         chk({keepalive_regulator_a_en, keepalive_regulator_b_en, rail_a_discharge_on,
            rail_b_discharge_on, uv_shutdown_latched}, rows[i].ka, "keep");
      end
      wt(60);
      tog();
      channel_on_cmd = 7'h0F;
      wt(6);
      chk(channel_discharge_on, 7'h50, "cmd discharge");
      {dscg_wr, dscg_wr_data, vcode_wr, vcode_wr_data} = {1'b1, 7'h7F, 1'b1, 18'h0_1000};
      wt(1);
      {dscg_wr, vcode_wr} = 2'h0;
      wt(4);
      chk(channel_discharge_on, 7'h70, "written discharge");
      chk(ch3_adjustable_mode, 1'b0, "fixed mode");
      enable_pin = 1'b0;
      wt(6);
      chk(channel_discharge_on, 7'h7F, "enable low discharge");
      channel_on_cmd = 7'h7F;
      logic_rail_por = 1'b1;
      wt(8);
      chk(channel_discharge_enable, FUSE_DSC, "por discharge");
      chk(channel_voltage_code, FUSE_VC, "por code");
      logic_rail_por = 1'b0;
      wt(60);
      tog();
      {ext_ok, sel_req} = 4'hF;
      wt(6);
      chk({rail_b_ext_connect, rail_a_ext_connect}, 2'h3, "takeover");
      for (int i = 0; i < 2; i++) begin
         ext_low[i] = 1'b1;
         wt(6);
         chk({rail_b_ext_connect, rail_a_ext_connect}, 2'h3 ^ (2'h1 << i), "low");
         ext_low[i] = 1'b0;
         ext_oc[i] = 1'b1;
         wt(6);
         ext_oc[i] = 1'b0;
         wt(10);
         chk({rail_b_ext_connect, rail_a_ext_connect}, 2'h3 ^ (2'h1 << i), "oc");
         enable_pin = 1'b0;
         wt(6);
         chk({rail_b_ext_connect, rail_a_ext_connect}, 2'h0, "enable low");
         enable_pin = 1'b1;
         wt(8);
         chk({rail_b_ext_connect, rail_a_ext_connect}, 2'h3, "toggle");
      end
      sel_req = 2'h0;
      valley_over_limit = 3'h5;
      wt(12);
      chk(pulse_skip, 3'h5, "skip");
      valley_over_limit = 3'h0;
      wt(12);
      chk(pulse_skip, 3'h0, "resume");
      short_ch = 7'h01;
      wt(8);
      chk({fault_flag, channel_power_good_flag[0], channel_undervoltage_flag[0]}, 3'h5,
         "flags low");
      short_ch = 7'h00;
      wt(8);
      chk({fault_flag, channel_power_good_flag[0], channel_undervoltage_flag[0]}, 3'h2,
         "flags ok");
      end_of_test();
   end
endmodule
`default_nettype wire
